// >>> bmcl_bus_agent.sv
// Model of the bus agents and core that raise error and retire events.
`timescale 1ns/1ps
`default_nettype none
module bmcl_bus_agent (
  input  wire logic                   clk,
  output var  bmcl_pkg::bmcl_event_t  evt,
  output var  bmcl_pkg::bmcl_core_t   core
);
  initial
  begin
    evt = '0;
    core = '0;
  end

  // Events last exactly one clock.
  task automatic fire(input bmcl_pkg::bmcl_event_t e,
                      input bmcl_pkg::bmcl_core_t c);
    @(posedge clk);
    evt <= e;
    core <= c;
    @(posedge clk);
    evt <= '0;
    core <= '0;
  endtask

  task automatic respond(input logic [2:0] st, input logic bad);
    bmcl_pkg::bmcl_event_t e;
    e = '0;
    e.resp_valid = 1'b1;
    e.response_status_pins = st;
    e.response_parity_pin = ^st ^ bad;
    fire(e, '0);
  endtask
endmodule
`default_nettype wire

// >>> bmcl_logger.sv
// Machine-check bank status logger for external bus errors.
// Operation
// - Queue type 100 single, 101 first parity
// - Bit 28 mismatch, bit 29 bus error
// - Bit 30 on own bus init
// - Bit 35 on received bus init
// - Bit 36 on response status parity error
// - Bit 37 on split access hard error
// - Bit 38 on retirement time-out
// - Time-out on 15-bit counter carry out
// - Counter steps on prescale timer carry
// - Counter cleared by four listed events
// - Time-out bit blocks later overwrites
// - Bit 42 hard error, locks log
// - Bit 43 internal failure, locks log
// - Bit 44 after two parity failures
// - Bit 45 uncorrected ECC, holds syndrome
// - Bit 46 on corrected ECC
// - Syndrome captured only when none held
// - Variant uses 23-bit time-out counter
// - Queue type 000 hard, 001 double, 010 second
// - Error code form 0000 1PPT RRRR IILL; compound_code is held at 0800, fields left zero
// - Bits 19-24 hold request type
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module bmcl_logger #(
  parameter bit          LONG_TIMEOUT = 1'b0,
  parameter int unsigned TMO_BITS     = bmcl_pkg::TMO_WIDTH
)(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire bmcl_pkg::bmcl_event_t evt,
  input  wire bmcl_pkg::bmcl_core_t  core,
  output logic                       timeout_init,
  output logic      [15:0]           compound_code
);

  localparam int unsigned CNT_W =
    LONG_TIMEOUT ? bmcl_pkg::TMO_WIDTH_ALT : TMO_BITS;

  logic [63:0] status;
  logic [1:0]  ratio;
  logic [1:0]  bus_div;
  logic        bus_tick;
  logic [bmcl_pkg::PRESCALE_WIDTH-1:0] prescale_timer;
  logic        prescale_carry;
  logic [CNT_W-1:0] tmo_cnt;
  logic        tmo_event;
  logic        addr_fail_seen;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_clr;
  logic        wr_cfg;
  logic        locked;
  logic        any_err;

  // Byte-enable merge of write data into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo  = req && wb_we_i && wb_adr_i == bmcl_pkg::REG_STATUS_LO;
  assign wr_hi  = req && wb_we_i && wb_adr_i == bmcl_pkg::REG_STATUS_HI;
  assign wr_clr = req && wb_we_i && wb_adr_i == bmcl_pkg::REG_CLEAR_HI;
  assign wr_cfg = req && wb_we_i && wb_adr_i == bmcl_pkg::REG_CONFIG;

  // Single-cycle ack; unmapped addresses read zero and ignore writes.
  always_ff @(posedge clk)
  begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
    begin
      case (wb_adr_i)
        bmcl_pkg::REG_STATUS_LO: wb_dat_o <= status[31:0];
        bmcl_pkg::REG_STATUS_HI: wb_dat_o <= status[63:32];
        bmcl_pkg::REG_CONFIG:    wb_dat_o <= {30'h0, ratio};
        default:                 wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ratio <= bmcl_pkg::RATIO_1_2;
    else if (wr_cfg && wb_sel_i[0])
      ratio <= wb_dat_i[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset || bus_tick)
      bus_div <= 2'h0;
    else
      bus_div <= bus_div + 2'h1;
  end
  always_comb
  begin
    case (ratio)
      bmcl_pkg::RATIO_1_3: bus_tick = bus_div == 2'h2;
      bmcl_pkg::RATIO_1_4: bus_tick = bus_div == 2'h3;
      default:             bus_tick = bus_div == 2'h1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      prescale_timer <= '0;
    else if (bus_tick)
    begin
      if (prescale_timer ==
          bmcl_pkg::PRESCALE_WIDTH'(bmcl_pkg::PRESCALE_DIV - 1))
        prescale_timer <= '0;
      else
        prescale_timer <= prescale_timer + 1'b1;
    end
  end
  assign prescale_carry = bus_tick && prescale_timer ==
    bmcl_pkg::PRESCALE_WIDTH'(bmcl_pkg::PRESCALE_DIV - 1);

  // Carry out of the high bit
  assign tmo_event = prescale_carry && (&tmo_cnt);

  always_ff @(posedge clk)
  begin
    if (reset || core.retire || core.exception || timeout_init)
      tmo_cnt <= '0;
    else if (prescale_carry)
      tmo_cnt <= tmo_cnt + 1'b1;
  end

  // Time-out drives the bus init that also clears the counter.
  always_ff @(posedge clk)
  begin
    if (reset)
      timeout_init <= 1'b0;
    else
      timeout_init <= tmo_event;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      addr_fail_seen <= 1'b0;
    else if (evt.addr_parity_fail)
      addr_fail_seen <= 1'b1;
    else if (wr_clr && wb_dat_i[bmcl_pkg::BIT_ADDRESS_PARITY_FAIL-32])
      addr_fail_seen <= 1'b0;
  end

  assign locked = status[bmcl_pkg::BIT_TMO] || status[bmcl_pkg::BIT_HARD]
               || status[bmcl_pkg::BIT_INTERNAL_FAILURE_PIN] || status[bmcl_pkg::BIT_ADDRESS_PARITY_FAIL];
  assign any_err = evt.single_err || evt.double_err || evt.hard_resp
                || evt.addr_parity_fail || evt.split_hard_resp;

  wire logic rs_parity_bad = evt.resp_valid &&
    ((^evt.response_status_pins) != evt.response_parity_pin);

  always_ff @(posedge clk)
  begin
    logic [63:0] s;
    s = status;
    if (reset)
      status <= 64'h0;
    else
    begin
      if (wr_lo)
        s[31:0] = merge(s[31:0], wb_dat_i, wb_sel_i)
                  & bmcl_pkg::WRITE_MASK[31:0];
      if (wr_hi)
        s[63:32] = merge(s[63:32], wb_dat_i, wb_sel_i)
                   & bmcl_pkg::WRITE_MASK[63:32];
      if (wr_clr)
        s[63:32] = s[63:32] & ~wb_dat_i;
      // Event sets come after writes so a set wins over a clear.
      if (any_err && !locked)
      begin
        s[bmcl_pkg::REQ_LSB +: 6] = evt.request_type;
        if (evt.hard_resp || evt.split_hard_resp)
          s[bmcl_pkg::QERR_LSB +: 3] = bmcl_pkg::QUEUE_ERROR_HARD;
        else if (evt.addr_parity_fail && addr_fail_seen)
          s[bmcl_pkg::QERR_LSB +: 3] =
            bmcl_pkg::QUEUE_ERROR_ADDR_PARITY_SECOND;
        else if (evt.addr_parity_fail)
          s[bmcl_pkg::QERR_LSB +: 3] =
            bmcl_pkg::QUEUE_ERROR_ADDR_PARITY_FIRST;
        else if (evt.double_err)
          s[bmcl_pkg::QERR_LSB +: 3] = bmcl_pkg::QUEUE_ERROR_DOUBLE;
        else
          s[bmcl_pkg::QERR_LSB +: 3] = bmcl_pkg::QUEUE_ERROR_SINGLE;
      end
      if (evt.redundancy_check_mismatch)
        s[bmcl_pkg::BIT_FRC] = 1'b1;
      if (evt.bus_error_output)
        s[bmcl_pkg::BIT_BUS_ERROR_OUTPUT] = 1'b1;
      if (evt.bus_init_drive || timeout_init)
        s[bmcl_pkg::BIT_IBINIT] = 1'b1;
      if (evt.bus_init_rx)
        s[bmcl_pkg::BIT_EBINIT] = 1'b1;
      if (rs_parity_bad)
        s[bmcl_pkg::BIT_RSPAR] = 1'b1;
      if (evt.split_hard_resp)
        s[bmcl_pkg::BIT_SPLIT] = 1'b1;
      if (tmo_event)
        s[bmcl_pkg::BIT_TMO] = 1'b1;
      if (evt.hard_resp)
        s[bmcl_pkg::BIT_HARD] = 1'b1;
      if (evt.internal_failure)
        s[bmcl_pkg::BIT_INTERNAL_FAILURE_PIN] = 1'b1;
      if (evt.addr_parity_fail && addr_fail_seen)
        s[bmcl_pkg::BIT_ADDRESS_PARITY_FAIL] = 1'b1;
      // Syndrome held while bit 45 set
      if ((evt.ecc_corrected || evt.ecc_uncorrectable)
          && !status[bmcl_pkg::BIT_UNCORRECTABLE_ECC_FLAG])
        s[bmcl_pkg::SYND_LSB +: 8] = evt.ecc_syndrome;
      if (evt.ecc_uncorrectable)
        s[bmcl_pkg::BIT_UNCORRECTABLE_ECC_FLAG] = 1'b1;
      if (evt.ecc_corrected)
        s[bmcl_pkg::BIT_CORRECTED_ECC_FLAG] = 1'b1;
      status <= s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      compound_code <= bmcl_pkg::COMPOUND_CODE_BASE;
    else
      compound_code <= bmcl_pkg::COMPOUND_CODE_BASE;
  end

  a_ack_one_cycle: assert property (@(posedge clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_single_type: assert property (@(posedge clk)
    disable iff (reset) evt.single_err && !locked && !evt.hard_resp
    && !evt.split_hard_resp && !evt.addr_parity_fail && !evt.double_err
    |=> status[bmcl_pkg::QERR_LSB +: 3] == bmcl_pkg::QUEUE_ERROR_SINGLE)
    else $error("single error type not logged");
  a_first_parity: assert property (@(posedge clk)
    disable iff (reset) evt.addr_parity_fail && !addr_fail_seen
    && !locked && !evt.hard_resp && !evt.split_hard_resp
    |=> status[bmcl_pkg::QERR_LSB +: 3] ==
      bmcl_pkg::QUEUE_ERROR_ADDR_PARITY_FIRST)
    else $error("first parity type not logged");
  a_frc_sets_bit: assert property (@(posedge clk)
    disable iff (reset) evt.redundancy_check_mismatch
    |=> status[bmcl_pkg::BIT_FRC]) else $error("mismatch bit not set");
  a_bus_error_output_sets_bit: assert property (@(posedge clk)
    disable iff (reset) evt.bus_error_output
    |=> status[bmcl_pkg::BIT_BUS_ERROR_OUTPUT]) else $error("bus error bit not set");
  a_own_init_bit: assert property (@(posedge clk)
    disable iff (reset) evt.bus_init_drive || timeout_init
    |=> status[bmcl_pkg::BIT_IBINIT]) else $error("own init bit not set");
  a_ext_init_bit: assert property (@(posedge clk)
    disable iff (reset) evt.bus_init_rx
    |=> status[bmcl_pkg::BIT_EBINIT]) else $error("rx init bit not set");
  a_rspar_sets_bit: assert property (@(posedge clk)
    disable iff (reset) rs_parity_bad |=> status[bmcl_pkg::BIT_RSPAR])
    else $error("response parity bit not set");
  a_split_sets_bit: assert property (@(posedge clk)
    disable iff (reset) evt.split_hard_resp
    |=> status[bmcl_pkg::BIT_SPLIT]) else $error("split bit not set");
  a_tmo_sets_bit: assert property (@(posedge clk)
    disable iff (reset) tmo_event |=> status[bmcl_pkg::BIT_TMO])
    else $error("time-out bit not set");
  a_prescale_wrap: assert property (@(posedge clk)
    disable iff (reset) prescale_carry |=> prescale_timer == '0)
    else $error("prescale timer did not wrap");
  a_tmo_init_clear: assert property (@(posedge clk)
    disable iff (reset) tmo_event |=> timeout_init ##1 tmo_cnt == '0)
    else $error("time-out init missing or counter not cleared");
  a_retire_clears: assert property (@(posedge clk)
    disable iff (reset) core.retire |=> tmo_cnt == '0)
    else $error("counter not cleared on retire");
  a_tmo_locks_log: assert property (@(posedge clk)
    disable iff (reset) status[bmcl_pkg::BIT_TMO] && !wr_lo
    |=> $stable(status[bmcl_pkg::REQ_LSB +: 9]))
    else $error("logged fields overwritten after time-out");
  a_hard_sets_bit: assert property (@(posedge clk)
    disable iff (reset) evt.hard_resp |=> status[bmcl_pkg::BIT_HARD])
    else $error("hard error bit not set");
  a_internal_failure_pin_sets_bit: assert property (@(posedge clk)
    disable iff (reset) evt.internal_failure
    |=> status[bmcl_pkg::BIT_INTERNAL_FAILURE_PIN]) else $error("internal bit not set");
  a_locked_fields: assert property (@(posedge clk)
    disable iff (reset) locked && !wr_lo
    |=> $stable(status[bmcl_pkg::REQ_LSB +: 9]))
    else $error("logged fields overwritten while locked");
  a_second_parity: assert property (@(posedge clk)
    disable iff (reset) evt.addr_parity_fail && addr_fail_seen
    |=> status[bmcl_pkg::BIT_ADDRESS_PARITY_FAIL]) else $error("parity bit not set");
  a_uncorrectable_ecc_flag_holds_syn: assert property (@(posedge clk)
    disable iff (reset) status[bmcl_pkg::BIT_UNCORRECTABLE_ECC_FLAG] && !wr_hi && !wr_clr
    |=> $stable(status[bmcl_pkg::SYND_LSB +: 8]))
    else $error("syndrome overwritten");
  a_corrected_ecc_flag_sets_bit: assert property (@(posedge clk)
    disable iff (reset) evt.ecc_corrected |=> status[bmcl_pkg::BIT_CORRECTED_ECC_FLAG])
    else $error("corrected ecc bit not set");
  a_syn_capture: assert property (@(posedge clk)
    disable iff (reset) (evt.ecc_corrected || evt.ecc_uncorrectable)
    && !status[bmcl_pkg::BIT_UNCORRECTABLE_ECC_FLAG]
    |=> status[bmcl_pkg::SYND_LSB +: 8] == $past(evt.ecc_syndrome))
    else $error("syndrome not captured");
  a_req_type_log: assert property (@(posedge clk)
    disable iff (reset) any_err && !locked
    |=> status[bmcl_pkg::REQ_LSB +: 6] == $past(evt.request_type))
    else $error("request type not logged");
  a_reserved_zero: assert property (@(posedge clk)
    disable iff (reset) (status & ~bmcl_pkg::WRITE_MASK) == 64'h0)
    else $error("reserved bit set");
  c_timeout: cover property (@(posedge clk) tmo_event);
  c_timeout_slow: cover property (@(posedge clk)
    tmo_event && ratio == bmcl_pkg::RATIO_1_4);
  c_split_hard: cover property (@(posedge clk) evt.split_hard_resp);
  c_uncorrectable_ecc_flag_then_corrected_ecc_flag: cover property (@(posedge clk)
    status[bmcl_pkg::BIT_UNCORRECTABLE_ECC_FLAG] ##1 evt.ecc_corrected);
  c_second_parity: cover property (@(posedge clk)
    evt.addr_parity_fail && addr_fail_seen);

endmodule

`default_nettype wire

// >>> bmcl_pkg.sv
// Package for the bus machine-check status logger.
package bmcl_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [3:0] REG_STATUS_LO  = 4'h0;
  localparam logic [3:0] REG_STATUS_HI  = 4'h4;
  localparam logic [3:0] REG_CLEAR_HI   = 4'h8;
  localparam logic [3:0] REG_CONFIG     = 4'hC;

  // Field positions inside the 64-bit status word.
  localparam int unsigned REQ_LSB     = 19;
  localparam int unsigned QERR_LSB    = 25;
  localparam int unsigned BIT_FRC     = 28;
  localparam int unsigned BIT_BUS_ERROR_OUTPUT    = 29;
  localparam int unsigned BIT_IBINIT  = 30;
  localparam int unsigned BIT_EBINIT  = 35;
  localparam int unsigned BIT_RSPAR   = 36;
  localparam int unsigned BIT_SPLIT   = 37;
  localparam int unsigned BIT_TMO     = 38;
  localparam int unsigned BIT_HARD    = 42;
  localparam int unsigned BIT_INTERNAL_FAILURE_PIN    = 43;
  localparam int unsigned BIT_ADDRESS_PARITY_FAIL    = 44;
  localparam int unsigned BIT_UNCORRECTABLE_ECC_FLAG    = 45;
  localparam int unsigned BIT_CORRECTED_ECC_FLAG    = 46;
  localparam int unsigned SYND_LSB    = 47;

  // Writable model-specific bits; reserved and architectural bits excluded.
  localparam logic [63:0] WRITE_MASK = 64'h007F_FC78_7FF8_0000;

  // Bus queue error type codes.
  localparam logic [2:0] QUEUE_ERROR_HARD              = 3'h0;
  localparam logic [2:0] QUEUE_ERROR_DOUBLE            = 3'h1;
  localparam logic [2:0] QUEUE_ERROR_ADDR_PARITY_SECOND = 3'h2;
  localparam logic [2:0] QUEUE_ERROR_SINGLE            = 3'h4;
  localparam logic [2:0] QUEUE_ERROR_ADDR_PARITY_FIRST = 3'h5;
  localparam logic [5:0] QUEUE_REQUEST_DATA_CACHE_READ = 6'h00;

  // Compound error code template, top nibbles 0000 1.
  localparam logic [15:0] COMPOUND_CODE_BASE = 16'h0800;

  // Timer figures.
  localparam int unsigned PRESCALE_WIDTH = 8;
  localparam int unsigned PRESCALE_DIV   = 128;
  localparam int unsigned TMO_WIDTH      = 15;
  localparam int unsigned TMO_WIDTH_ALT  = 23;
  localparam int unsigned MAX_WIDTH      = 23;

  // Bus clock ratio choices held in the config register.
  localparam logic [1:0] RATIO_1_2 = 2'h0;
  localparam logic [1:0] RATIO_1_3 = 2'h1;
  localparam logic [1:0] RATIO_1_4 = 2'h2;

  // Error events from the bus unit, all one-cycle pulses.
  typedef struct packed {
    logic       single_err;
    logic       double_err;
    logic       hard_resp;
    logic       split_hard_resp;
    logic       addr_parity_fail;
    logic       redundancy_check_mismatch;
    logic       bus_error_output;
    logic       bus_init_drive;
    logic       bus_init_rx;
    logic       resp_valid;
    logic [2:0] response_status_pins;
    logic       response_parity_pin;
    logic       internal_failure;
    logic       ecc_corrected;
    logic       ecc_uncorrectable;
    logic [7:0] ecc_syndrome;
    logic [5:0] request_type;
  } bmcl_event_t;

  // Core retirement activity, one-cycle pulses.
  typedef struct packed {
    logic retire;
    logic exception;
  } bmcl_core_t;
endpackage

// >>> tb_top.sv
// Self-checking bench for the bus machine-check status logger.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk;
  logic                  reset;
  logic                  cyc;
  logic                  stb;
  logic                  we;
  logic [3:0]            adr;
  logic [3:0]            sel;
  logic [31:0]           wdat;
  logic [31:0]           rdat;
  logic                  ack;
  logic                  tinit;
  logic [15:0]           ccode;
  bmcl_pkg::bmcl_event_t evt;
  bmcl_pkg::bmcl_core_t  core;
  int                    failures;
  int                    total_checks;

  bmcl_logger #(.TMO_BITS(2)) u_bmcl_logger (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .evt(evt), .core(core),
    .timeout_init(tinit), .compound_code(ccode));
  bmcl_bus_agent u_bmcl_bus_agent (.clk(clk), .evt(evt), .core(core));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      final_report();
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd64(output logic [63:0] v);
    wb(1'b0, 4'h0, 32'h0, v[31:0]);
    wb(1'b0, 4'h4, 32'h0, v[63:32]);
  endtask

  task automatic clr;
    wr(4'h8, 32'hFFFF_FFFF);
    wr(4'h0, 32'h0);
  endtask

  function automatic bmcl_pkg::bmcl_event_t mk(input int k);
    bmcl_pkg::bmcl_event_t e;
    e = '0;
    e.request_type = 6'h2B;
    case (k)
      0: e.single_err = 1'b1;
      1: e.double_err = 1'b1;
      2: e.addr_parity_fail = 1'b1;
      3: e.hard_resp = 1'b1;
      4: e.redundancy_check_mismatch = 1'b1;
      5: e.bus_error_output = 1'b1;
      6: e.bus_init_drive = 1'b1;
      7: e.bus_init_rx = 1'b1;
      8: e.split_hard_resp = 1'b1;
      9: e.internal_failure = 1'b1;
      default: e.ecc_corrected = 1'b1;
    endcase
    return e;
  endfunction

  task automatic qev(input int k, input logic [2:0] t,
                     input logic [31:0] hi);
    u_bmcl_bus_agent.fire(mk(k), '0);
    rd(4'h0, {4'h0, t, 6'h2B, 19'h0});
    rd(4'h4, hi);
    wr(4'h0, 32'h0);
  endtask

  task automatic t_regs;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    chk({16'h0, ccode}, 32'h0000_0800);
    wr(4'h0, 32'hFFFF_FFFF);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h0, bmcl_pkg::WRITE_MASK[31:0]);
    rd(4'h4, bmcl_pkg::WRITE_MASK[63:32]);
    clr;
    rd(4'h4, 32'h0);
  endtask

  task automatic t_queue;
    qev(0, 3'h4, 32'h0);
    qev(1, 3'h1, 32'h0);
    qev(2, 3'h5, 32'h0);
    qev(2, 3'h2, 32'h1000);
    clr;
    u_bmcl_bus_agent.fire(mk(3), '0);
    u_bmcl_bus_agent.fire(mk(0) ^ 6'h3A, '0);
    rd(4'h0, {7'h0, 6'h2B, 19'h0});
    rd(4'h4, 32'h400);
    clr;
  endtask

  task automatic t_flags;
    int pos [7] = '{28, 29, 30, 35, 37, 43, 46};
    logic [63:0] v;
    for (int i = 0; i < 7; i++)
    begin
      u_bmcl_bus_agent.fire(mk(i + 4), '0);
      rd64(v);
      chk({31'h0, v[pos[i]]}, 32'h1);
      clr;
    end
  endtask

  task automatic t_ecc;
    bmcl_pkg::bmcl_event_t e;
    e = '0;
    e.ecc_uncorrectable = 1'b1;
    e.ecc_syndrome = 8'hA5;
    u_bmcl_bus_agent.fire(e, '0);
    rd(4'h4, 32'h2000 | (32'hA5 << 15));
    e = '0;
    e.ecc_corrected = 1'b1;
    e.ecc_syndrome = 8'h3C;
    u_bmcl_bus_agent.fire(e, '0);
    rd(4'h4, 32'h6000 | (32'hA5 << 15));
    wr(4'h8, 32'h2000);
    u_bmcl_bus_agent.fire(e, '0);
    rd(4'h4, 32'h4000 | (32'h3C << 15));
    clr;
    u_bmcl_bus_agent.respond(3'h3, 1'b0);
    rd(4'h4, 32'h0);
    u_bmcl_bus_agent.respond(3'h3, 1'b1);
    rd(4'h4, 32'h10);
    clr;
  endtask

  task automatic t_timeout;
    bmcl_pkg::bmcl_core_t c;
    logic [63:0] v;
    int n;
    int k;
    for (int r = 0; r < 3; r++)
    begin
      k = (r + 2) * 128;
      wr(4'hC, 32'(r));
      rd(4'hC, 32'(r));
      c = '0;
      c.retire = 1'b1;
      u_bmcl_bus_agent.fire('0, c);
      repeat (600) @(posedge clk);
      c = '0;
      c.exception = 1'b1;
      u_bmcl_bus_agent.fire('0, c);
      n = 0;
      while (tinit !== 1'b1 && n < 8 * k)
      begin
        @(posedge clk);
        n++;
      end
      chk(32'(n > 3 * k && n <= 4 * k + 4), 32'h1);
      if (tinit !== 1'b1)
        final_report();
      rd64(v);
      chk({30'h0, v[38], v[30]}, 32'h3);
      clr;
    end
  endtask

  initial
  begin
    failures = 0;
    total_checks = 0;
    reset = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_queue;
    t_flags;
    t_ecc;
    t_timeout;
    final_report;
  end
endmodule
`default_nettype wire
